// ===== bench/hdlc_tx_fifo_status_tb.sv
// self-checking bench for the transmit fifo block
// assumes htxf_pkg, the framer model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module hdlc_tx_fifo_status_tb;
    localparam logic [11:0] A_C = htxf_pkg::ADDR_CTRL;
    localparam logic [11:0] A_D = htxf_pkg::ADDR_DATA;
    localparam logic [11:0] A_S = htxf_pkg::ADDR_STAT;
    localparam logic [11:0] A_L = htxf_pkg::ADDR_LTCH;
    localparam logic [11:0] A_E = htxf_pkg::ADDR_IREN;
    localparam logic [11:0] A_P = htxf_pkg::ADDR_PORT;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, bit_req;
    logic tx_bit, tx_valid, tx_pend, ram_pd, irq, perr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, strb;
    int failures = 0;
    int n_compared = 0;
    int cyc = 0;

    htxf_top i_htxf_top (.i_clk(clk), .i_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
        .i_pwdata(pwdata), .i_pstrb(pstrb), .o_pready(pready),
        .o_prdata(prdata), .o_pslverr(pslverr), .i_bit_req(bit_req),
        .o_tx_bit(tx_bit), .o_tx_bit_valid(tx_valid),
        .o_tx_pkt_end(tx_pend), .o_ram_pd(ram_pd), .o_irq(irq));
    htxf_framer_model i_htxf_framer_model (.i_clk(clk), .i_tx_bit(tx_bit),
        .i_tx_bit_valid(tx_valid), .i_tx_pkt_end(tx_pend),
        .o_bit_req(bit_req));

    // -----------------------------------------------------------------
    // clock, timeout and tasks
    // -----------------------------------------------------------------
    // 25 ns clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= strb;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        if (n == 64) failures++;
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdc(input string nm, input logic [11:0] a,
                       input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
    endtask : rdc
    // pull one byte; an expected count of F skips the count check
    task automatic pb(input int gap, input logic [7:0] eb,
                      input logic [3:0] env, input logic epe);
        logic [7:0] b;
        logic [3:0] nv;
        logic pe;
        i_htxf_framer_model.pull_byte(gap, b, nv, pe);
        chk("bits", {24'h0, eb}, {24'h0, b});
        if (env != 4'hF) chk("nvalid", {28'h0, env}, {28'h0, nv});
        chk("pkt_end", {31'h0, epe}, {31'h0, pe});
    endtask : pb

    // -----------------------------------------------------------------
    // test sequence
    // -----------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        strb = 4'hF;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        rdc("ctrl", A_C, 32'h00001000);
        rdc("enables", A_E, 32'h0);
        rdc("status", A_S, 32'h00002003);
        wr(A_L, 32'h3F);
        rdc("latched", A_L, 32'h0);
        rdc("unmapped", 12'h2AC, 32'h0);
        chk("slverr", 32'h1, {31'h0, perr});
        wr(A_E, 32'h3F);
        wr(A_P, 32'h1);
        chk("irq", 32'h0, {31'h0, irq});
        wr(A_D, 32'h0000A500);
        rdc("status", A_S, 32'h00001F01);
        wr(A_D, 32'h00001E01);
        rdc("data", A_D, 32'h0);
        pb(0, 8'hA5, 4'h8, 1'b0);
        wr(A_C, 32'h00001008);
        pb(3, 8'h78, 4'h8, 1'b1);
        rdc("latched", A_L, 32'h0A);
        chk("irq", 32'h1, {31'h0, irq});
        wr(A_P, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        wr(A_P, 32'h1);
        wr(A_L, 32'h3F);
        rdc("latched", A_L, 32'h0);
        chk("irq", 32'h0, {31'h0, irq});
        wr(A_C, 32'h00001000);
        strb = 4'h2;
        wr(A_D, 32'h00008101);
        strb = 4'hF;
        pb(0, 8'h81, 4'h8, 1'b0);
        pb(0, 8'hFF, 4'h8, 1'b0);
        rdc("latched", A_L, 32'h12);
        wr(A_L, 32'h3F);
        for (int i = 0; i < 257; i++) begin
            wr(A_D, {16'h0, i[7:0], 8'h00});
            if (i == 126) rdc("st129", A_S, 32'h00001001);
            if (i == 127) rdc("st128", A_S, 32'h00001000);
            if (i == 254) rdc("st1", A_S, 32'h0);
            if (i == 255) rdc("stfull", A_S, 32'h00000004);
        end
        rdc("latched", A_L, 32'h24);
        pb(0, 8'h00, 4'h8, 1'b0);
        rdc("st1", A_S, 32'h0);
        wr(A_C, 32'h00001001);
        chk("ram_pd", 32'h1, {31'h0, ram_pd});
        wr(A_D, 32'h00005501);
        pb(0, 8'hFF, 4'h0, 1'b0);
        rdc("status", A_S, 32'h00002003);
        wr(A_L, 32'h3F);
        wr(A_C, 32'h00001000);
        rdc("latched", A_L, 32'h03);
        chk("ram_pd", 32'h0, {31'h0, ram_pd});
        print_verdict();
    end
endmodule : hdlc_tx_fifo_status_tb
`default_nettype wire

// ===== bench/htxf_framer_model.sv
// framer model pulling serial bits from the transmit fifo block
// assumes the bench calls pull_byte; requests change after rising edges
// and the task returns right after a rising edge, ready for bus traffic
`timescale 1ns/1ps
`default_nettype none
module htxf_framer_model (
    input wire logic i_clk,
    input wire logic i_tx_bit,
    input wire logic i_tx_bit_valid,
    input wire logic i_tx_pkt_end,
    output logic o_bit_req
);
    initial o_bit_req = 1'b0;

    // eight requests; first bit seen lands in bit 0
    task automatic pull_byte(input int gap, output logic [7:0] bits,
                             output logic [3:0] nv, output logic pe);
        nv = 4'h0;
        pe = 1'b0;
        for (int k = 0; k < 8; k++) begin
            @(posedge i_clk);
            o_bit_req <= 1'b1;
            @(posedge i_clk);
            o_bit_req <= 1'b0;
            @(negedge i_clk);
            bits[k] = i_tx_bit;
            nv = nv + {3'h0, i_tx_bit_valid};
            pe = pe | i_tx_pkt_end;
            repeat (gap) @(posedge i_clk);
        end
        // hand back on a rising edge so the next bus call starts cleanly
        @(posedge i_clk);
    endtask : pull_byte
endmodule : htxf_framer_model
`default_nettype wire

// ===== bench/htxf_top_sva.sv
// checker for the transmit fifo block, bound to htxf_top
// assumes the port list of htxf_top and one clock domain
`timescale 1ns/1ps
`default_nettype none
module htxf_top_sva (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic o_pready,
    input wire logic [31:0] o_prdata,
    input wire logic o_pslverr,
    input wire logic i_bit_req,
    input wire logic o_tx_bit,
    input wire logic o_tx_bit_valid,
    input wire logic o_tx_pkt_end,
    input wire logic o_ram_pd,
    input wire logic o_irq
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic mapped;
    logic port_en_ff;

    // -----------------------------------------------------------------
    // helpers and properties
    // -----------------------------------------------------------------
    // register hit decode
    assign mapped = i_paddr inside {htxf_pkg::ADDR_CTRL, htxf_pkg::ADDR_DATA,
        htxf_pkg::ADDR_STAT, htxf_pkg::ADDR_LTCH, htxf_pkg::ADDR_IREN,
        htxf_pkg::ADDR_PORT};
    // shadow of the port interrupt enable
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            port_en_ff <= 1'b0;
        end else if (i_psel && i_penable && i_pwrite && i_pstrb[0]
                     && i_paddr == htxf_pkg::ADDR_PORT) begin
            port_en_ff <= i_pwdata[0];
        end
    end
    sequence s_setup_rd;
        i_psel && !i_penable && !i_pwrite;
    endsequence
    sequence s_wr(a);
        i_psel && i_penable && i_pwrite && i_pstrb[0] && i_paddr == a;
    endsequence
    property p_data_reads_zero;
        s_setup_rd ##0 (i_paddr == htxf_pkg::ADDR_DATA) |=> o_prdata == 32'h0;
    endproperty
    a_data_reads_zero: assert property (p_data_reads_zero)
        else $error("data register read not zero");
    property p_idle_high;
        !o_tx_bit_valid |-> o_tx_bit;
    endproperty
    a_idle_high: assert property (p_idle_high)
        else $error("bit line not idle high");
    property p_req_gives_bit;
        i_bit_req && !o_ram_pd |=> o_tx_bit_valid;
    endproperty
    a_req_gives_bit: assert property (p_req_gives_bit)
        else $error("bit request got no bit");
    property p_valid_needs_req;
        o_tx_bit_valid |-> $past(i_bit_req) && !$past(o_ram_pd);
    endproperty
    a_valid_needs_req: assert property (p_valid_needs_req)
        else $error("bit valid without request or during flush");
    property p_pkt_end_on_bit;
        o_tx_pkt_end |-> o_tx_bit_valid;
    endproperty
    a_pkt_end_on_bit: assert property (p_pkt_end_on_bit)
        else $error("packet end without a bit");
    property p_flush_follows_ctrl;
        s_wr(htxf_pkg::ADDR_CTRL) |=> o_ram_pd == $past(i_pwdata[0]);
    endproperty
    a_flush_follows_ctrl: assert property (p_flush_follows_ctrl)
        else $error("ram power down not following flush");
    property p_irq_gated;
        !port_en_ff |-> !o_irq;
    endproperty
    a_irq_gated: assert property (p_irq_gated)
        else $error("irq while port enable off");
    property p_unmapped_err;
        i_psel && i_penable |-> o_pslverr == !mapped;
    endproperty
    a_unmapped_err: assert property (p_unmapped_err)
        else $error("slave error not matching address map");
endmodule : htxf_top_sva
bind htxf_top htxf_top_sva i_htxf_top_sva (.i_clk, .i_rst, .i_psel,
    .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_pready,
    .o_prdata, .o_pslverr, .i_bit_req, .o_tx_bit, .o_tx_bit_valid,
    .o_tx_pkt_end, .o_ram_pd, .o_irq);
`default_nettype wire

// ===== hdl/htxf_pkg.sv
// constants, register map and types of the transmit-side hdlc fifo block
// assumes a 32-bit apb slave port with word-aligned registers
package htxf_pkg;

    // -----------------------------------------------------------------
    // register indices and byte addresses
    // -----------------------------------------------------------------
    localparam logic [11:0] IDX_CTRL = 12'h0A0;
    localparam logic [11:0] IDX_DATA = 12'h0A2;
    localparam logic [11:0] IDX_STAT = 12'h0A4;
    localparam logic [11:0] IDX_LTCH = 12'h0A6;
    localparam logic [11:0] IDX_IREN = 12'h0A8;
    localparam logic [11:0] IDX_PORT = 12'h0AA;
    localparam logic [11:0] ADDR_CTRL = 12'h280;
    localparam logic [11:0] ADDR_DATA = 12'h288;
    localparam logic [11:0] ADDR_STAT = 12'h290;
    localparam logic [11:0] ADDR_LTCH = 12'h298;
    localparam logic [11:0] ADDR_IREN = 12'h2A0;
    localparam logic [11:0] ADDR_PORT = 12'h2A8;

    // -----------------------------------------------------------------
    // field positions
    // -----------------------------------------------------------------
    localparam int CTRL_FLUSH_BIT = 0;
    localparam int CTRL_MSB_BIT = 3;
    localparam int CTRL_THR_LSB = 8;
    localparam int DATA_END_BIT = 0;
    localparam int DATA_BYTE_LSB = 8;
    localparam int STAT_GROUPS_LSB = 8;
    localparam int EV_SPACE = 0;
    localparam int EV_EMPTY = 1;
    localparam int EV_FULL = 2;
    localparam int EV_PKTEND = 3;
    localparam int EV_UNDER = 4;
    localparam int EV_OVER = 5;
    localparam int PORT_IRQ_BIT = 0;

    // -----------------------------------------------------------------
    // reset values and sizes
    // -----------------------------------------------------------------
    localparam logic [4:0] RST_THR = 5'h10;
    localparam logic RST_FLUSH = 1'b0;
    localparam logic RST_MSB = 1'b0;
    localparam logic [5:0] RST_IREN = 6'h00;
    localparam logic RST_PORT_EN = 1'b0;
    localparam int FIFO_DEPTH = 256;
    localparam logic [8:0] FIFO_FULL_CNT = 9'h100;
    localparam logic [2:0] BITS_LEFT_INIT = 3'h7;
    localparam logic IDLE_BIT = 1'b1;

    // one stored fifo entry
    typedef struct packed {
        logic pkt_end;
        logic [7:0] data;
    } htxf_entry_t;

    // live fifo status
    typedef struct packed {
        logic [5:0] free_groups;
        logic full;
        logic empty;
        logic space_avail;
    } htxf_status_t;

    // serializer states
    typedef enum logic [0:0] {
        SER_IDLE = 1'b0,
        SER_SHIFT = 1'b1
    } htxf_ser_t;

    // register selector
    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_CTRL = 3'b001,
        SEL_DATA = 3'b010,
        SEL_STAT = 3'b011,
        SEL_LTCH = 3'b100,
        SEL_IREN = 3'b101,
        SEL_PORT = 3'b110
    } htxf_sel_t;

endpackage : htxf_pkg

// ===== hdl/htxf_top.sv
// transmit-side hdlc fifo with status, latched events and interrupt
// assumes an apb master on i_clk and a framer that pulls bits on i_bit_req
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - upper byte write pushes byte; end mark only when byte lane zero is also strobed
// - data register always reads back zero
// - lsb first normally, msb first when reordering
// - end mark bit zero flags packet end
// - free space reported in eight-byte groups
// - full bit set only when fifo full
// - empty bit set when no bytes held
// - space bit set when free meets threshold
// - overflow latched on write into full fifo
// - underflow latched when packet data runs dry
// - packet end latched when end entry popped
// - empty latched on rise and flush release
// - space latched on rise and flush release
// - interrupt from latched, enabled, port-enabled flags
// - full latched on rising edge of full
// - flush empties, halts, powers down, ignores data writes
// - threshold needs eight times value plus one
// - reorder control selects msb first order
module htxf_top (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    output logic o_pready,
    output logic [31:0] o_prdata,
    output logic o_pslverr,
    input wire logic i_bit_req,
    output logic o_tx_bit,
    output logic o_tx_bit_valid,
    output logic o_tx_pkt_end,
    output logic o_ram_pd,
    output logic o_irq
);

    // -----------------------------------------------------------------
    // helpers
    // -----------------------------------------------------------------

    // address decode shared by read and write paths
    function automatic htxf_pkg::htxf_sel_t decode(input logic [11:0] a);
        case (a)
            htxf_pkg::ADDR_CTRL: decode = htxf_pkg::SEL_CTRL;
            htxf_pkg::ADDR_DATA: decode = htxf_pkg::SEL_DATA;
            htxf_pkg::ADDR_STAT: decode = htxf_pkg::SEL_STAT;
            htxf_pkg::ADDR_LTCH: decode = htxf_pkg::SEL_LTCH;
            htxf_pkg::ADDR_IREN: decode = htxf_pkg::SEL_IREN;
            htxf_pkg::ADDR_PORT: decode = htxf_pkg::SEL_PORT;
            default: decode = htxf_pkg::SEL_NONE;
        endcase
    endfunction : decode

    // bit reversal for msb-first order
    function automatic logic [7:0] reverse8(input logic [7:0] b);
        for (int i = 0; i < 8; i++) begin
            reverse8[i] = b[7 - i];
        end
    endfunction : reverse8

    // -----------------------------------------------------------------
    // declarations
    // -----------------------------------------------------------------
    logic [4:0] thr_ff;
    logic flush_ff;
    logic msb_first_ff;
    logic [5:0] iren_ff;
    logic port_en_ff;
    logic [5:0] latched_ff;
    logic [5:0] nxt_latched;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    logic slverr_ff;
    logic [8:0] mem [htxf_pkg::FIFO_DEPTH];
    logic [7:0] wr_ptr_ff;
    logic [7:0] rd_ptr_ff;
    logic [8:0] count_ff;
    logic prev_empty_ff;
    logic prev_space_ff;
    logic prev_full_ff;
    logic prev_flush_ff;
    htxf_pkg::htxf_ser_t ser_ff;
    logic [6:0] shift_ff;
    logic [2:0] bits_left_ff;
    logic in_pkt_ff;
    logic tx_bit_ff;
    logic tx_valid_ff;
    logic tx_end_ff;
    htxf_pkg::htxf_sel_t sel;
    htxf_pkg::htxf_status_t stat;
    htxf_pkg::htxf_entry_t wr_entry;
    htxf_pkg::htxf_entry_t rd_entry;
    logic setup;
    logic wr_acc;
    logic push_req;
    logic push;
    logic pop;
    logic [8:0] free_bytes;
    logic [8:0] thr_bytes;
    logic [7:0] ordered;
    logic underflow;
    logic [5:0] events;
    logic [5:0] clr_mask;

    // -----------------------------------------------------------------
    // apb slave
    // -----------------------------------------------------------------

    // decode and phase strobes
    assign sel = decode(i_paddr);
    assign setup = i_psel && !i_penable;
    assign wr_acc = i_psel && i_penable && i_pwrite;
    assign o_pready = i_psel && i_penable;
    assign o_prdata = prdata_ff;
    assign o_pslverr = slverr_ff && i_psel && i_penable;

    // read mux, sampled in setup so data comes from a flop
    always_comb begin
        nxt_prdata = 32'h00000000;
        case (sel)
            htxf_pkg::SEL_CTRL: begin
                nxt_prdata[htxf_pkg::CTRL_THR_LSB +: 5] = thr_ff;
                nxt_prdata[htxf_pkg::CTRL_MSB_BIT] = msb_first_ff;
                nxt_prdata[htxf_pkg::CTRL_FLUSH_BIT] = flush_ff;
            end
            htxf_pkg::SEL_DATA: nxt_prdata = 32'h00000000;
            htxf_pkg::SEL_STAT: begin
                nxt_prdata[htxf_pkg::STAT_GROUPS_LSB +: 6] = stat.free_groups;
                nxt_prdata[htxf_pkg::EV_FULL] = stat.full;
                nxt_prdata[htxf_pkg::EV_EMPTY] = stat.empty;
                nxt_prdata[htxf_pkg::EV_SPACE] = stat.space_avail;
            end
            htxf_pkg::SEL_LTCH: nxt_prdata[5:0] = latched_ff;
            htxf_pkg::SEL_IREN: nxt_prdata[5:0] = iren_ff;
            htxf_pkg::SEL_PORT: nxt_prdata[htxf_pkg::PORT_IRQ_BIT] = port_en_ff;
            default: nxt_prdata = 32'h00000000;
        endcase
    end

    // read data and error flag captured at setup
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            prdata_ff <= 32'h00000000;
            slverr_ff <= 1'b0;
        end else if (setup) begin
            prdata_ff <= i_pwrite ? 32'h00000000 : nxt_prdata;
            slverr_ff <= (sel == htxf_pkg::SEL_NONE);
        end
    end

    // control register
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            thr_ff <= htxf_pkg::RST_THR;
            msb_first_ff <= htxf_pkg::RST_MSB;
            flush_ff <= htxf_pkg::RST_FLUSH;
        end else if (wr_acc && sel == htxf_pkg::SEL_CTRL) begin
            if (i_pstrb[1]) begin
                thr_ff <= i_pwdata[htxf_pkg::CTRL_THR_LSB +: 5];
            end
            if (i_pstrb[0]) begin
                msb_first_ff <= i_pwdata[htxf_pkg::CTRL_MSB_BIT];
                flush_ff <= i_pwdata[htxf_pkg::CTRL_FLUSH_BIT];
            end
        end
    end

    // interrupt enables and port enable
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            iren_ff <= htxf_pkg::RST_IREN;
            port_en_ff <= htxf_pkg::RST_PORT_EN;
        end else if (wr_acc && i_pstrb[0]) begin
            if (sel == htxf_pkg::SEL_IREN) begin
                iren_ff <= i_pwdata[5:0];
            end
            if (sel == htxf_pkg::SEL_PORT) begin
                port_en_ff <= i_pwdata[htxf_pkg::PORT_IRQ_BIT];
            end
        end
    end

    // -----------------------------------------------------------------
    // fifo storage
    // -----------------------------------------------------------------

    // upper byte lane write forms one entry
    assign push_req = wr_acc && sel == htxf_pkg::SEL_DATA && i_pstrb[1];
    assign wr_entry.data = i_pwdata[htxf_pkg::DATA_BYTE_LSB +: 8];
    assign wr_entry.pkt_end = i_pwdata[htxf_pkg::DATA_END_BIT] && i_pstrb[0];
    assign push = push_req && !flush_ff && !stat.full;
    assign rd_entry = mem[rd_ptr_ff];

    // entry memory
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_ff] <= wr_entry;
        end
    end

    // pointers and fill count; flush empties the fifo
    always_ff @(posedge i_clk) begin
        if (i_rst || flush_ff) begin
            wr_ptr_ff <= 8'h00;
            rd_ptr_ff <= 8'h00;
            count_ff <= 9'h000;
        end else begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 8'h01;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 8'h01;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 9'h001;
            end else if (pop && !push) begin
                count_ff <= count_ff - 9'h001;
            end
        end
    end

    // ram power-down follows the flush control
    assign o_ram_pd = flush_ff;

    // -----------------------------------------------------------------
    // live status
    // -----------------------------------------------------------------

    // free space, groups and threshold compare
    assign free_bytes = htxf_pkg::FIFO_FULL_CNT - count_ff;
    assign thr_bytes = {1'b0, thr_ff, 3'b000} + 9'h001;
    assign stat.free_groups = free_bytes[8:3];
    assign stat.full = (count_ff == htxf_pkg::FIFO_FULL_CNT);
    assign stat.empty = (count_ff == 9'h000);
    assign stat.space_avail = (free_bytes >= thr_bytes);

    // -----------------------------------------------------------------
    // serializer towards the framer
    // -----------------------------------------------------------------

    // byte is put in send order when loaded
    assign ordered = msb_first_ff ? reverse8(rd_entry.data) : rd_entry.data;
    assign pop = i_bit_req && ser_ff == htxf_pkg::SER_IDLE && !stat.empty
                 && !flush_ff;
    assign underflow = i_bit_req && ser_ff == htxf_pkg::SER_IDLE
                       && stat.empty && in_pkt_ff && !flush_ff;

    // bit shifter state machine
    always_ff @(posedge i_clk) begin
        if (i_rst || flush_ff) begin
            ser_ff <= htxf_pkg::SER_IDLE;
            shift_ff <= 7'h00;
            bits_left_ff <= 3'h0;
        end else begin
            case (ser_ff)
                htxf_pkg::SER_IDLE: begin
                    if (pop) begin
                        shift_ff <= ordered[7:1];
                        bits_left_ff <= htxf_pkg::BITS_LEFT_INIT;
                        ser_ff <= htxf_pkg::SER_SHIFT;
                    end
                end
                htxf_pkg::SER_SHIFT: begin
                    if (i_bit_req) begin
                        shift_ff <= {1'b0, shift_ff[6:1]};
                        bits_left_ff <= bits_left_ff - 3'h1;
                        if (bits_left_ff == 3'h1) begin
                            ser_ff <= htxf_pkg::SER_IDLE;
                        end
                    end
                end
                default: ser_ff <= htxf_pkg::SER_IDLE;
            endcase
        end
    end

    // output bit, one per request; idle ones when nothing to send
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            tx_bit_ff <= htxf_pkg::IDLE_BIT;
            tx_valid_ff <= 1'b0;
            tx_end_ff <= 1'b0;
        end else begin
            tx_valid_ff <= i_bit_req && !flush_ff;
            tx_end_ff <= pop && rd_entry.pkt_end;
            if (flush_ff || !i_bit_req) begin
                tx_bit_ff <= htxf_pkg::IDLE_BIT;
            end else if (ser_ff == htxf_pkg::SER_SHIFT) begin
                tx_bit_ff <= shift_ff[0];
            end else if (pop) begin
                tx_bit_ff <= ordered[0];
            end else begin
                tx_bit_ff <= htxf_pkg::IDLE_BIT;
            end
        end
    end
    assign o_tx_bit = tx_bit_ff;
    assign o_tx_bit_valid = tx_valid_ff;
    assign o_tx_pkt_end = tx_end_ff;

    // packet tracking for underflow detection
    always_ff @(posedge i_clk) begin
        if (i_rst || flush_ff) begin
            in_pkt_ff <= 1'b0;
        end else if (pop) begin
            in_pkt_ff <= !rd_entry.pkt_end;
        end else if (underflow) begin
            in_pkt_ff <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // events, latched flags and interrupt
    // -----------------------------------------------------------------

    // edge history
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            prev_empty_ff <= 1'b1;
            prev_space_ff <= 1'b1;
            prev_full_ff <= 1'b0;
            prev_flush_ff <= 1'b0;
        end else begin
            prev_empty_ff <= stat.empty;
            prev_space_ff <= stat.space_avail;
            prev_full_ff <= stat.full;
            prev_flush_ff <= flush_ff;
        end
    end

    // event pulses
    always_comb begin
        events = 6'h00;
        events[htxf_pkg::EV_OVER] = push_req && !flush_ff && stat.full;
        events[htxf_pkg::EV_UNDER] = underflow;
        events[htxf_pkg::EV_PKTEND] = pop && rd_entry.pkt_end;
        events[htxf_pkg::EV_FULL] = stat.full && !prev_full_ff;
        events[htxf_pkg::EV_EMPTY] = (stat.empty && !prev_empty_ff)
                                     || (prev_flush_ff && !flush_ff);
        events[htxf_pkg::EV_SPACE] = (stat.space_avail && !prev_space_ff)
                                     || (prev_flush_ff && !flush_ff);
    end

    // write one to clear; a new event wins over the clear
    assign clr_mask = (wr_acc && sel == htxf_pkg::SEL_LTCH && i_pstrb[0])
                      ? i_pwdata[5:0] : 6'h00;
    assign nxt_latched = (latched_ff & ~clr_mask) | events;

    // sticky flags
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            latched_ff <= 6'h00;
        end else begin
            latched_ff <= nxt_latched;
        end
    end

    // level interrupt
    assign o_irq = port_en_ff && |(latched_ff & iren_ff);

endmodule : htxf_top

`default_nettype wire
